//--- rcms_checker.sv
`timescale 1ns/100ps
module rcms_checker (
   input wire logic        CLK,         // System clock
   input wire logic        RST_N,       // Pin reset
   input wire logic        LVD_BELOW,   // Supply low
   input wire logic        AWVALID,     // Write address valid
   input wire logic        AWREADY,     // Write address ready
   input wire logic [7:0]  AWADDR,      // Write address
   input wire logic [31:0] WDATA,       // Write data
   input wire logic [3:0]  WSTRB,       // Write strobes
   input wire logic        SYS_RST_N,   // System reset
   input wire logic        CPU_RUN,     // CPU released
   input wire logic        CPU_CLK_INT, // CPU on internal
   input wire logic [2:0]  CLK_DIV,     // Divider code
   input wire logic        MAIN_OSC_EN, // Main oscillator enable
   input wire logic        LVD_IRQ      // Low-voltage pulse
);
   logic [1:0] lv_q;
   logic [2:0] below_q;

   // Mirror of the low-voltage enable and select bits
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         lv_q <= 2'h0;
      end else if (AWVALID && AWREADY && AWADDR == 8'h00 && WSTRB[0]) begin
         lv_q <= WDATA[1:0];
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         below_q <= 3'h0;
      end else if (!LVD_BELOW) begin
         below_q <= 3'h0;
      end else if (below_q != 3'h7) begin
         below_q <= below_q + 3'h1;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   osc_off_a:
      assert property (!SYS_RST_N |-> !MAIN_OSC_EN) else $error("main osc on in reset");
   run_gated_a:
      assert property (CPU_RUN |-> SYS_RST_N) else $error("cpu runs in reset");
   run_late_a:
      assert property ($rose(CPU_RUN) |-> $past(SYS_RST_N, 8)) else $error("cpu released early");
   div_eight_a:
      assert property ($rose(CPU_RUN) |-> CLK_DIV == 3'h3) else $error("divider not eight");
   emerg_run_a:
      assert property (CPU_CLK_INT |-> CPU_RUN) else $error("internal clock without run");
   lv_pulse_a:
      assert property (LVD_IRQ |=> !LVD_IRQ) else $error("irq longer than a cycle");
   lv_cause_a:
      assert property (LVD_IRQ |-> $past(LVD_BELOW, 2) != $past(LVD_BELOW, 4))
         else $error("irq without crossing");
   lv_reset_a:
      assert property (lv_q == 2'h3 && below_q == 3'h7 |-> !SYS_RST_N)
         else $error("no low-voltage reset");

   cover property ($rose(CPU_RUN));
   cover property ($rose(CPU_CLK_INT));
   cover property (LVD_IRQ);
   cover property ($fell(SYS_RST_N));
endmodule

bind rcms_top rcms_checker chk_i (.CLK, .RST_N, .LVD_BELOW, .AWVALID, .AWREADY, .AWADDR,
   .WDATA, .WSTRB, .SYS_RST_N, .CPU_RUN, .CPU_CLK_INT, .CLK_DIV, .MAIN_OSC_EN, .LVD_IRQ);

//--- rcms_clkmon.sv
`timescale 1ns/100ps
`include "rcms_consts.svh"
module rcms_clkmon (
   input  wire logic clk,   // System clock
   input  wire logic rst_n, // Synchronised reset
   rcms_mon_if.mon   mon    // Link to the sequencer
);

   logic [2:0] cnt_q;
   logic       req_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 3'h0;
      end else if (!mon.active || mon.main_edge) begin
         cnt_q <= 3'h0;
      end else if (mon.int_tick && cnt_q != `RCMS_CLKMON_TICKS) begin
         cnt_q <= cnt_q + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_q <= 1'b0;
      end else begin
         req_q <= mon.active && mon.int_tick && !mon.main_edge
                  && cnt_q == `RCMS_CLKMON_TICKS - 3'h1;
      end
   end

   assign mon.stop_req = req_q;

endmodule

//--- rcms_consts.svh
`ifndef RCMS_CONSTS_SVH
`define RCMS_CONSTS_SVH

// Register byte offsets
`define RCMS_OFS_LV_MODE     8'h00
`define RCMS_OFS_CLK_CTRL    8'h04
`define RCMS_OFS_CLKMON_MODE 8'h08
`define RCMS_OFS_RESET_SRC   8'h0c
`define RCMS_OFS_CPU_STATUS  8'h10
`define RCMS_OFS_DEBUG_MODE  8'h14
`define RCMS_OFS_WDT_COUNT   8'h18

// Low-voltage mode register fields
`define RCMS_LV_ENABLE_BIT   0
`define RCMS_LV_RSEL_BIT     1
`define RCMS_LV_BELOW_BIT    2

// Clock control register fields
`define RCMS_CC_MCK_BIT      0
`define RCMS_CC_CLS_BIT      1
`define RCMS_CC_ISTOP_BIT    2
`define RCMS_CC_DIV_LSB      4
`define RCMS_CC_DIV_MSB      6

// Reset source register fields
`define RCMS_RS_CLKMON_BIT   0
`define RCMS_RS_LV_BIT       1

// CPU clock status register fields
`define RCMS_ST_INTOSC_BIT   0
`define RCMS_ST_RUN_BIT      1
`define RCMS_ST_STAB_BIT     2

// Reset values
`define RCMS_DIV_RESET       3'h3
`define RCMS_DEBUG_RESET     1'h1

// Timing counts in CLK cycles and internal oscillator ticks
`define RCMS_HOLD_CYCLES     3'h4
`define RCMS_CLKMON_TICKS    3'h4

// AXI responses
`define RCMS_RESP_OKAY       2'h0
`define RCMS_RESP_SLVERR     2'h2

`endif

//--- rcms_mon_if.sv
`timescale 1ns/100ps
interface rcms_mon_if;
   logic active;
   logic int_tick;
   logic main_edge;
   logic stop_req;

   modport seq (output active, output int_tick, output main_edge, input stop_req);
   modport mon (input active, input int_tick, input main_edge, output stop_req);
endinterface

//--- rcms_osc_model.sv
`timescale 1ns/100ps
module rcms_osc_model #(
   parameter int MAIN_HALF = 2, // Main half period, cycles
   parameter int INT_HALF  = 8  // Internal half period, cycles
) (
   input  wire logic clk,       // Bench clock
   input  wire logic main_en,   // Main oscillator enable
   input  wire logic int_en,    // Internal oscillator enable
   input  wire logic main_fail, // Crystal fault
   output logic      main_clk,  // Main oscillator output
   output logic      int_clk    // Internal oscillator output
);
   int main_n = 0;
   int int_n  = 0;

   // A stopped or faulty oscillator sits low
   always @(posedge clk) begin
      if (!main_en || main_fail) begin
         main_clk <= 1'b0;
         main_n   <= 0;
      end else if (main_n == MAIN_HALF - 1) begin
         main_clk <= ~main_clk;
         main_n   <= 0;
      end else begin
         main_n <= main_n + 1;
      end
   end

   always @(posedge clk) begin
      if (!int_en) begin
         int_clk <= 1'b0;
         int_n   <= 0;
      end else if (int_n == INT_HALF - 1) begin
         int_clk <= ~int_clk;
         int_n   <= 0;
      end else begin
         int_n <= int_n + 1;
      end
   end
endmodule

//--- rcms_pkg.sv
package rcms_pkg;

   typedef enum logic [1:0] {
      SEQ_HOLD,
      SEQ_STAB,
      SEQ_RUN_MAIN,
      SEQ_RUN_EMERG
   } rcms_seq_type;

endpackage

//--- rcms_top.sv
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`include "rcms_consts.svh"
module rcms_top #(
   parameter int STAB_W    = 24, // Stabilisation counter width
   parameter int STAB_BASE = 10, // Log2 of shortest wait in main ticks
   parameter int WDT_W     = 12  // Secondary watchdog width
) (
   input  wire logic        CLK,         // System clock
   input  wire logic        RST_N,       // Pin reset, active low
   input  wire logic        LVD_BELOW,   // Supply below detection level
   input  wire logic        MAIN_OSC_CLK, // Main oscillator sample
   input  wire logic        INT_OSC_CLK, // Internal oscillator sample
   input  wire logic        STOP_STAB,   // STOP exit stabilisation busy
   input  wire logic [2:0]  STAB_SEL,    // Option byte wait select
   input  wire logic        AWVALID,     // Write address valid
   output logic             AWREADY,     // Write address ready
   input  wire logic [7:0]  AWADDR,      // Write address
   input  wire logic        WVALID,      // Write data valid
   output logic             WREADY,      // Write data ready
   input  wire logic [31:0] WDATA,       // Write data
   input  wire logic [3:0]  WSTRB,       // Write strobes
   output logic             BVALID,      // Write response valid
   input  wire logic        BREADY,      // Write response ready
   output logic [1:0]       BRESP,       // Write response
   input  wire logic        ARVALID,     // Read address valid
   output logic             ARREADY,     // Read address ready
   input  wire logic [7:0]  ARADDR,      // Read address
   output logic             RVALID,      // Read data valid
   input  wire logic        RREADY,      // Read data ready
   output logic [31:0]      RDATA,       // Read data
   output logic [1:0]       RRESP,       // Read response
   output logic             SYS_RST_N,   // System reset, active low
   output logic             CPU_RUN,     // CPU released
   output logic             CPU_CLK_INT, // CPU on internal oscillator
   output logic [2:0]       CLK_DIV,     // System clock divider code
   output logic             MAIN_OSC_EN, // Main oscillator enable
   output logic             INT_OSC_EN,  // Internal oscillator enable
   output logic             LVD_IRQ,     // Low-voltage interrupt pulse
   output logic             DEBUG_MODE   // Debug mode control bit
);

   logic                rst_s1_q;
   logic                rst_n;
   logic [2:0]          in_s1_q;
   logic [2:0]          in_s2_q;
   logic [2:0]          in_s3_q;
   logic                below;
   logic                main_edge;
   logic                int_tick;
   rcms_pkg::rcms_seq_type state_q;
   rcms_pkg::rcms_seq_type state_d;
   logic [2:0]          hold_cnt_q;
   logic [STAB_W-1:0]   stab_cnt_q;
   logic [STAB_W-1:0]   stab_lim;
   logic [2:0]          stab_sel_q;
   logic [WDT_W-1:0]    wdt_q;
   logic                wdt_ovf;
   logic                lv_en_q;
   logic                lv_rsel_q;
   logic                lv_rst;
   logic                cm_req;
   logic                enter_hold;
   logic                mck_q;
   logic                cls_q;
   logic                istop_q;
   logic [2:0]          div_q;
   logic                clkmon_en_q;
   logic                mck_susp_q;
   logic                rs_clkmon_q;
   logic                rs_lv_q;
   logic                debug_q;
   logic                wr_go;
   logic                rd_go;
   logic                wr_hit;
   logic [31:0]         rd_data;
   logic                rd_hit;
   logic                int_run;
   rcms_mon_if          mon_if ();

   // Reset release through two flip-flops
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   // Asynchronous inputs: two stages, third only for edge detection
   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge CLK or negedge rst_n) begin
         if (!rst_n) begin
            in_s1_q[i] <= 1'b0;
            in_s2_q[i] <= 1'b0;
            in_s3_q[i] <= 1'b0;
         end else begin
            in_s1_q[i] <= (i == 0) ? LVD_BELOW : (i == 1) ? MAIN_OSC_CLK : INT_OSC_CLK;
            in_s2_q[i] <= in_s1_q[i];
            in_s3_q[i] <= in_s2_q[i];
         end
      end
   end

   assign below     = in_s2_q[0];
   assign main_edge = in_s2_q[1] && !in_s3_q[1];
   assign int_tick  = in_s2_q[2] && !in_s3_q[2] && INT_OSC_EN;

   // low-voltage reset condition, held while below
   assign lv_rst     = lv_en_q && lv_rsel_q && below;
   assign cm_req     = mon_if.stop_req;
   assign enter_hold = lv_rst || cm_req;

   // wait length from captured option select
   assign stab_lim = {{(STAB_W-1){1'b0}}, 1'b1} << (STAB_BASE + int'(stab_sel_q));

   assign wdt_ovf = int_tick && (&wdt_q);

   // sampling clock running outside reset unless stopped by software, a stop ignored in emergency run
   assign int_run = state_q != rcms_pkg::SEQ_HOLD
                    && !(istop_q && state_q != rcms_pkg::SEQ_RUN_EMERG);

   always_comb begin
      state_d = state_q;
      case (state_q)
         rcms_pkg::SEQ_HOLD: begin
            if (!lv_rst && hold_cnt_q == `RCMS_HOLD_CYCLES) begin
               state_d = rcms_pkg::SEQ_STAB;
            end
         end
         rcms_pkg::SEQ_STAB: begin
            if (wdt_ovf) begin
               state_d = rcms_pkg::SEQ_RUN_EMERG;
            end else if (stab_cnt_q >= stab_lim) begin
               state_d = rcms_pkg::SEQ_RUN_MAIN;
            end
         end
         default: begin
            state_d = state_q;
         end
      endcase
      if (enter_hold) begin
         state_d = rcms_pkg::SEQ_HOLD;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= rcms_pkg::SEQ_HOLD;
      end else begin
         state_q <= state_d;
      end
   end

   // minimum hold, restarted on every new request
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt_q <= 3'h0;
      end else if (state_q != rcms_pkg::SEQ_HOLD || enter_hold) begin
         hold_cnt_q <= 3'h0;
      end else if (hold_cnt_q != `RCMS_HOLD_CYCLES) begin
         hold_cnt_q <= hold_cnt_q + 3'h1;
      end
   end

   // option select caught while held in reset
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         stab_sel_q <= 3'h0;
      end else if (state_q == rcms_pkg::SEQ_HOLD) begin
         stab_sel_q <= STAB_SEL;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         stab_cnt_q <= '0;
      end else if (state_q != rcms_pkg::SEQ_STAB) begin
         stab_cnt_q <= '0;
      end else if (main_edge && stab_cnt_q < stab_lim) begin
         stab_cnt_q <= stab_cnt_q + {{(STAB_W-1){1'b0}}, 1'b1};
      end
   end

   // watchdog cleared in reset, counts internal ticks
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         wdt_q <= '0;
      end else if (state_q == rcms_pkg::SEQ_HOLD) begin
         wdt_q <= '0;
      end else if (int_tick) begin
         wdt_q <= wdt_q + {{(WDT_W-1){1'b0}}, 1'b1};
      end
   end

   // Clock monitor hookup
   // suspend conditions
   assign mon_if.active    = clkmon_en_q && state_q == rcms_pkg::SEQ_RUN_MAIN
                             && !STOP_STAB && !mck_susp_q && !mck_q && int_run;
   assign mon_if.int_tick  = int_tick;
   assign mon_if.main_edge = main_edge;

   rcms_clkmon u_clkmon (
      .clk   (CLK),
      .rst_n (rst_n),
      .mon   (mon_if.mon)
   );

   // main stop latched until subclock and main stop bits both cleared
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         mck_susp_q <= 1'b0;
      end else if (state_q == rcms_pkg::SEQ_HOLD) begin
         mck_susp_q <= 1'b0;
      end else if (mck_q && cls_q) begin
         mck_susp_q <= 1'b1;
      end else if (!cls_q && !mck_q) begin
         mck_susp_q <= 1'b0;
      end
   end

   // Bus slave: address and data taken together
   assign wr_go = AWVALID && WVALID && !AWREADY && !BVALID;
   assign rd_go = ARVALID && !ARREADY && !RVALID;
   assign wr_hit = AWREADY && WSTRB[0];

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         AWREADY <= 1'b0;
         WREADY  <= 1'b0;
         BVALID  <= 1'b0;
         BRESP   <= `RCMS_RESP_OKAY;
      end else begin
         AWREADY <= wr_go;
         WREADY  <= wr_go;
         if (AWREADY) begin
            BVALID <= 1'b1;
            BRESP  <= (AWADDR <= `RCMS_OFS_WDT_COUNT && AWADDR[1:0] == 2'h0)
                      ? `RCMS_RESP_OKAY : `RCMS_RESP_SLVERR;
         end else if (BREADY) begin
            BVALID <= 1'b0;
         end
      end
   end

   // Low-voltage mode: pin reset only
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         lv_en_q   <= 1'b0;
         lv_rsel_q <= 1'b0;
      end else if (wr_hit && AWADDR == `RCMS_OFS_LV_MODE) begin
         lv_en_q   <= WDATA[`RCMS_LV_ENABLE_BIT];
         lv_rsel_q <= WDATA[`RCMS_LV_RSEL_BIT];
      end
   end

   // clock control and divider back to eight on any reset
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         mck_q   <= 1'b0;
         cls_q   <= 1'b0;
         istop_q <= 1'b0;
         div_q   <= `RCMS_DIV_RESET;
      end else if (state_q == rcms_pkg::SEQ_HOLD) begin
         mck_q   <= 1'b0;
         cls_q   <= 1'b0;
         istop_q <= 1'b0;
         div_q   <= `RCMS_DIV_RESET;
      end else if (wr_hit && AWADDR == `RCMS_OFS_CLK_CTRL) begin
         mck_q   <= WDATA[`RCMS_CC_MCK_BIT];
         cls_q   <= WDATA[`RCMS_CC_CLS_BIT];
         istop_q <= WDATA[`RCMS_CC_ISTOP_BIT];
         div_q   <= WDATA[`RCMS_CC_DIV_MSB:`RCMS_CC_DIV_LSB];
      end
   end

   // enable sticky, cleared only by reset
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         clkmon_en_q <= 1'b0;
      end else if (state_q == rcms_pkg::SEQ_HOLD) begin
         clkmon_en_q <= 1'b0;
      end else if (wr_hit && AWADDR == `RCMS_OFS_CLKMON_MODE && WDATA[0]) begin
         clkmon_en_q <= 1'b1;
      end
   end

   // reset source flags, set beats write-one clear
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rs_clkmon_q <= 1'b0;
         rs_lv_q     <= 1'b0;
      end else begin
         if (cm_req) begin
            rs_clkmon_q <= 1'b1;
         end else if (wr_hit && AWADDR == `RCMS_OFS_RESET_SRC
                      && WDATA[`RCMS_RS_CLKMON_BIT]) begin
            rs_clkmon_q <= 1'b0;
         end
         if (lv_rst) begin
            rs_lv_q <= 1'b1;
         end else if (wr_hit && AWADDR == `RCMS_OFS_RESET_SRC
                      && WDATA[`RCMS_RS_LV_BIT]) begin
            rs_lv_q <= 1'b0;
         end
      end
   end

   // debug control kept across internal resets
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         debug_q <= `RCMS_DEBUG_RESET;
      end else if (wr_hit && AWADDR == `RCMS_OFS_DEBUG_MODE) begin
         debug_q <= WDATA[0];
      end
   end

   // Read decode
   always_comb begin
      rd_data = 32'h0;
      rd_hit  = 1'b1;
      if (ARADDR == `RCMS_OFS_LV_MODE) begin
         rd_data[`RCMS_LV_ENABLE_BIT] = lv_en_q;
         rd_data[`RCMS_LV_RSEL_BIT]   = lv_rsel_q;
         rd_data[`RCMS_LV_BELOW_BIT]  = below;
      end else if (ARADDR == `RCMS_OFS_CLK_CTRL) begin
         rd_data[`RCMS_CC_MCK_BIT]   = mck_q;
         rd_data[`RCMS_CC_CLS_BIT]   = cls_q;
         rd_data[`RCMS_CC_ISTOP_BIT] = istop_q;
         rd_data[`RCMS_CC_DIV_MSB:`RCMS_CC_DIV_LSB] = div_q;
      end else if (ARADDR == `RCMS_OFS_CLKMON_MODE) begin
         rd_data[0] = clkmon_en_q;
      end else if (ARADDR == `RCMS_OFS_RESET_SRC) begin
         rd_data[`RCMS_RS_CLKMON_BIT] = rs_clkmon_q;
         rd_data[`RCMS_RS_LV_BIT]     = rs_lv_q;
      end else if (ARADDR == `RCMS_OFS_CPU_STATUS) begin
         rd_data[`RCMS_ST_INTOSC_BIT] = state_q == rcms_pkg::SEQ_RUN_EMERG;
         rd_data[`RCMS_ST_RUN_BIT]    = CPU_RUN;
         rd_data[`RCMS_ST_STAB_BIT]   = state_q == rcms_pkg::SEQ_STAB;
      end else if (ARADDR == `RCMS_OFS_DEBUG_MODE) begin
         rd_data[0] = debug_q;
      end else if (ARADDR == `RCMS_OFS_WDT_COUNT) begin
         rd_data[WDT_W-1:0] = wdt_q;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b0;
         RDATA   <= 32'h0;
         RRESP   <= `RCMS_RESP_OKAY;
      end else begin
         ARREADY <= rd_go;
         if (ARREADY) begin
            RVALID <= 1'b1;
            RDATA  <= rd_data;
            RRESP  <= rd_hit ? `RCMS_RESP_OKAY : `RCMS_RESP_SLVERR;
         end else if (RREADY) begin
            RVALID <= 1'b0;
         end
      end
   end

   // interrupt on either crossing in interrupt mode
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         LVD_IRQ <= 1'b0;
      end else begin
         LVD_IRQ <= lv_en_q && !lv_rsel_q && (in_s2_q[0] != in_s3_q[0]);
      end
   end

   // Registered outputs, reset, run and oscillator controls from next state
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         SYS_RST_N   <= 1'b0;
         CPU_RUN     <= 1'b0;
         CPU_CLK_INT <= 1'b0;
         MAIN_OSC_EN <= 1'b0;
         INT_OSC_EN  <= 1'b0;
         CLK_DIV     <= `RCMS_DIV_RESET;
         DEBUG_MODE  <= `RCMS_DEBUG_RESET;
      end else begin
         SYS_RST_N   <= state_d != rcms_pkg::SEQ_HOLD;
         CPU_RUN     <= state_d == rcms_pkg::SEQ_RUN_MAIN
                        || state_d == rcms_pkg::SEQ_RUN_EMERG;
         CPU_CLK_INT <= state_d == rcms_pkg::SEQ_RUN_EMERG;
         MAIN_OSC_EN <= state_d != rcms_pkg::SEQ_HOLD && !mck_q;
         INT_OSC_EN  <= state_d != rcms_pkg::SEQ_HOLD
                        && !(istop_q && state_d != rcms_pkg::SEQ_RUN_EMERG);
         CLK_DIV     <= div_q;
         DEBUG_MODE  <= debug_q;
      end
   end

endmodule

//--- reset_and_clock_monitor_sequencer_bench.sv
`timescale 1ns/100ps
module reset_and_clock_monitor_sequencer_bench;
   logic        CLK = 1'b0;
   logic        RST_N, LVD_BELOW, MAIN_OSC_CLK, INT_OSC_CLK, STOP_STAB, main_fail;
   logic [2:0]  STAB_SEL, CLK_DIV;
   logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
   logic        ARVALID, ARREADY, RVALID, RREADY;
   logic [7:0]  AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA, rd_q, seed_q, wd_q;
   logic [3:0]  WSTRB;
   logic [1:0]  BRESP, RRESP;
   logic        SYS_RST_N, CPU_RUN, CPU_CLK_INT, MAIN_OSC_EN, INT_OSC_EN, LVD_IRQ, DEBUG_MODE;
   int          bad_count, n_tests, irq_n, cyc, i, k;

   rcms_top #(.STAB_BASE(2), .WDT_W(5)) dut (.CLK, .RST_N, .LVD_BELOW, .MAIN_OSC_CLK,
      .INT_OSC_CLK, .STOP_STAB, .STAB_SEL, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY,
      .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID,
      .RREADY, .RDATA, .RRESP, .SYS_RST_N, .CPU_RUN, .CPU_CLK_INT, .CLK_DIV, .MAIN_OSC_EN,
      .INT_OSC_EN, .LVD_IRQ, .DEBUG_MODE);

   rcms_osc_model osc (.clk(CLK), .main_en(MAIN_OSC_EN), .int_en(INT_OSC_EN),
      .main_fail(main_fail), .main_clk(MAIN_OSC_CLK), .int_clk(INT_OSC_CLK));

   always #2 CLK = ~CLK;

   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (LVD_IRQ === 1'b1) irq_n <= irq_n + 1;
      if (cyc == 60000) begin
         bad_count++;
         stop_test();
      end
   end

   // Shortest wait: main edges of the stabilisation count, four cycles apart
   function automatic int min_wait(input logic [2:0] s);
      return 4 * ((1 << (2 + s)) - 1);
   endfunction

   task stop_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      AWVALID <= 1'b1;
      WVALID  <= 1'b1;
      AWADDR  <= a;
      WDATA   <= d;
      BREADY  <= 1'b1;
      do begin
         @(posedge CLK);
         if (AWREADY === 1'b1) AWVALID <= 1'b0;
         if (WREADY === 1'b1) WVALID <= 1'b0;
      end while (BVALID !== 1'b1);
      BREADY <= 1'b0;
      chk("bresp", BRESP, 2'h0);
   endtask

   task rdr(input logic [7:0] a);
      @(posedge CLK);
      ARVALID <= 1'b1;
      ARADDR  <= a;
      RREADY  <= 1'b1;
      do begin
         @(posedge CLK);
         if (ARREADY === 1'b1) ARVALID <= 1'b0;
      end while (RVALID !== 1'b1);
      RREADY <= 1'b0;
      rd_q = RDATA;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      rdr(a);
      chk($sformatf("reg %h", a), rd_q, e);
      chk("rresp", RRESP, er);
   endtask

   task boot();
      for (i = 0; i < 400 && SYS_RST_N !== 1'b1; i++) @(posedge CLK);
      for (k = 0; k < 3000 && CPU_RUN !== 1'b1; k++) @(posedge CLK);
      chk("cpu run", CPU_RUN, 1'b1);
      chk("stab wait", 32'(k >= min_wait(STAB_SEL)), 1);
      $display("boot done");
   endtask

   initial begin
      {RST_N, LVD_BELOW, STOP_STAB, main_fail, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
      {AWADDR, ARADDR, WDATA} = '0;
      WSTRB = 4'hf;
      {bad_count, n_tests, irq_n, cyc} = '0;
      seed_q = $urandom(52451);
      STAB_SEL = 3'($urandom % 4);
      // clock-through only: the model offers no PLL path
      repeat (6) @(posedge CLK);
      RST_N <= 1'b1;
      boot();
      rd(8'h04, 32'h30, 2'h0);
      rd(8'h08, 32'h0, 2'h0);
      rd(8'h14, 32'h1, 2'h0);
      rd(8'h10, 32'h2, 2'h0);
      rd(8'h1c, 32'h0, 2'h2);
      rdr(8'h18);
      wd_q = rd_q;
      repeat (64) @(posedge CLK);
      rdr(8'h18);
      chk("wdt step", 32'((rd_q[4:0] - wd_q[4:0]) inside {5'h4, 5'h5}), 1);
      $display("start-up done");

      wr(8'h08, $urandom | 32'h1);
      rd(8'h08, 32'h1, 2'h0);
      wr(8'h08, 32'h0);
      rd(8'h08, 32'h1, 2'h0);
      wr(8'h14, $urandom & 32'hfffffffe);
      main_fail <= 1'b1;
      for (i = 0; i < 200 && SYS_RST_N !== 1'b0; i++) @(posedge CLK);
      chk("monitor reset", SYS_RST_N, 1'b0);
      main_fail <= 1'b0;
      boot();
      rd(8'h0c, 32'h1, 2'h0);
      rd(8'h08, 32'h0, 2'h0);
      rd(8'h14, 32'h0, 2'h0);
      chk("debug kept", DEBUG_MODE, 1'b0);
      wr(8'h0c, 32'h3);
      rd(8'h0c, 32'h0, 2'h0);
      $display("monitor done");

      for (k = 0; k < 3; k++) begin
         wr(8'h08, 32'h1);
         if (k == 0) STOP_STAB <= 1'b1;
         if (k == 1) wr(8'h04, 32'h33);
         if (k == 2) wr(8'h04, 32'h34);
         main_fail <= 1'b1;
         repeat (150) @(posedge CLK);
         chk("suspended", SYS_RST_N, 1'b1);
         if (k == 1) chk("main stop", MAIN_OSC_EN, 1'b0);
         if (k == 2) chk("int osc stop", INT_OSC_EN, 1'b0);
         STOP_STAB <= 1'b0;
         main_fail <= 1'b0;
         wr(8'h04, 32'h30);
         repeat (20) @(posedge CLK);
      end
      $display("suspend done");

      wr(8'h00, 32'h1);
      irq_n = 0;
      for (k = 0; k < 4; k++) begin
         LVD_BELOW <= ~LVD_BELOW;
         repeat (20 + $urandom % 30) @(posedge CLK);
      end
      chk("irq count", irq_n, 4);
      chk("no reset", SYS_RST_N, 1'b1);
      $display("interrupt done");

      wr(8'h00, 32'h3);
      LVD_BELOW <= 1'b1;
      repeat (10) @(posedge CLK);
      chk("lv reset", SYS_RST_N, 1'b0);
      chk("osc stop", MAIN_OSC_EN, 1'b0);
      repeat (100) @(posedge CLK);
      chk("lv hold", SYS_RST_N, 1'b0);
      main_fail <= 1'b1;
      LVD_BELOW <= 1'b0;
      for (i = 0; i < 2000 && CPU_CLK_INT !== 1'b1; i++) @(posedge CLK);
      chk("emergency", CPU_CLK_INT, 1'b1);
      // emergency software touches only status and monitor bits
      rd(8'h10, 32'h3, 2'h0);
      rd(8'h0c, 32'h2, 2'h0);
      wr(8'h08, 32'h1);
      repeat (150) @(posedge CLK);
      chk("no monitor", SYS_RST_N, 1'b1);
      $display("emergency done");

      RST_N <= 1'b0;
      repeat (6) @(posedge CLK);
      STAB_SEL <= 3'($urandom % 4);
      main_fail <= 1'b0;
      RST_N <= 1'b1;
      @(posedge CLK);
      boot();
      rd(8'h08, 32'h0, 2'h0);
      rd(8'h14, 32'h1, 2'h0);
      chk("debug pin", DEBUG_MODE, 1'b1);
      rd(8'h00, 32'h0, 2'h0);
      $display("pin reset done");
      stop_test();
   end
endmodule
